//--- mxr_pkg.sv
// package for the return, logic and control instruction executor
package mxr_pkg;

	// operation codes presented on the instruction port
	typedef enum logic [3:0] {
		OP_NOP = 4'h0,
		OP_RETURN = 4'h1,
		OP_RET_IRQ = 4'h2,
		OP_RET_LIT = 4'h3,
		OP_ROT_L = 4'h4,
		OP_ROT_R = 4'h5,
		OP_SUB = 4'h6,
		OP_SWAP = 4'h7,
		OP_XOR_F = 4'h8,
		OP_DIR_LOAD = 4'h9,
		OP_XOR_LIT = 4'ha,
		OP_SLEEP = 4'hb
	} mxr_op_t;

	// one issued instruction
	typedef struct packed {
		mxr_op_t op;
		logic [7:0] lit;  // literal or direction register selector
		logic [4:0] faddr;  // file register address
		logic dest;  // 0 accumulator, 1 file register
	} mxr_instr_t;

	// arithmetic and power status flags
	typedef struct packed {
		logic timeout_flag;
		logic powerdown_flag;
		logic zero;
		logic digit_carry_flag;
		logic carry;
	} mxr_flags_t;

	// register bus offsets
	localparam logic [2:0] REG_ACC = 3'h0;
	localparam logic [2:0] REG_STATUS = 3'h1;
	localparam logic [2:0] REG_IRQ_CTRL = 3'h2;
	localparam logic [2:0] REG_DIR_BASE = 3'h3;
	localparam int IRQ_ENABLE_BIT = 7;
	localparam int DIR_COUNT = 3;
	localparam logic [7:0] DIR_FIRST = 8'h06;
	localparam logic [7:0] DIR_LAST = 8'h08;

	// reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] DIR_RST = 8'hff;
	localparam mxr_flags_t FLAGS_RST = 5'h18;
	localparam logic DEST_ACC = 1'b0;

endpackage

//--- mxr_exec.sv
// executor for return, register logic and control instructions
// Notes on behaviour
// - irq return reloads pc, enables irqs, two cycles
// - literal return: literal to acc, pc from stack
// - plain return: pc from stack, two cycles
// - dest 0 writes acc, 1 writes file
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - sleep clears watchdog, halts core
// - sleep sets timeout, clears powerdown flag
// - file minus acc, updates carry, digit carry, zero
// - swap nibbles to destination, no flags
// - xor acc with file, zero flag only
// - direction load from acc, selector 6..8
// - xor literal into acc, zero flag
`timescale 1ns/1ps

module mxr_exec #(
	parameter int PC_W = 11
) (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic INSTR_VALID,
	input wire mxr_pkg::mxr_instr_t INSTR,
	input wire logic [7:0] FILE_RDATA,
	input wire logic [PC_W-1:0] STACK_TOP,
	input wire logic WAKE,
	input wire logic [2:0] BUS_ADDR,
	input wire logic [7:0] BUS_WDATA,
	input wire logic BUS_WR,
	input wire logic BUS_RD,
	output logic [7:0] BUS_RDATA,
	output logic BUSY,
	output logic SLEEPING,
	output logic PC_LOAD,
	output logic [PC_W-1:0] PC_VALUE,
	output logic FILE_WE,
	output logic [4:0] FILE_WADDR,
	output logic [7:0] FILE_WDATA,
	output logic WATCHDOG_CLEAR,
	output logic [7:0] ACC,
	output mxr_pkg::mxr_flags_t FLAGS,
	output logic GLOBAL_IRQ_ENABLE,
	output logic [mxr_pkg::DIR_COUNT-1:0][7:0] PIN_DIR
);

	////////////////////////////////////////////////////////////////////////////
	// state

	// whole module state in one record
	typedef struct packed {
		logic [7:0] acc;
		mxr_pkg::mxr_flags_t flags;
		logic global_irq_enable;
		logic [mxr_pkg::DIR_COUNT-1:0][7:0] dir;
		logic busy;  // second cycle of a return
		logic sleep;  // core halted
		logic pc_load;
		logic [PC_W-1:0] pc;
		logic fwe;
		logic [4:0] faddr;
		logic [7:0] fdata;
		logic watchdog_clr;
		logic [7:0] rdata;
	} mxr_state_t;

	mxr_state_t st_q;
	mxr_state_t st_d;

	// zero test shared by several operations
	function automatic logic is_zero(input logic [7:0] v);
		return v == 8'h00;
	endfunction

	// direction selector decode, valid only for 6, 7 or 8
	function automatic logic dir_hit(input logic [7:0] sel, input logic [7:0] idx);
		return (sel >= mxr_pkg::DIR_FIRST) && (sel <= mxr_pkg::DIR_LAST)
			&& (sel - mxr_pkg::DIR_FIRST == idx);
	endfunction

	// instruction accepted only when idle and awake
	logic take;
	assign take = INSTR_VALID && !st_q.busy && !st_q.sleep;

	// nine-bit sum gives borrow-free carry for subtract
	logic [8:0] sub_full;
	logic [4:0] sub_low;
	assign sub_full = {1'b0, FILE_RDATA} + {1'b0, ~st_q.acc} + 9'h001;
	assign sub_low = {1'b0, FILE_RDATA[3:0]} + {1'b0, ~st_q.acc[3:0]} + 5'h01;

	////////////////////////////////////////////////////////////////////////////
	// next state

	// bus writes first, instructions override the same field after
	always_comb begin
		logic [7:0] res;
		logic wr_res;
		res = 8'h00;
		wr_res = 1'b0;
		st_d = st_q;
		st_d.pc_load = 1'b0;
		st_d.fwe = 1'b0;
		st_d.watchdog_clr = 1'b0;
		st_d.busy = 1'b0;
		st_d.rdata = 8'h00;
		// register reads, unmapped offsets read zero
		if (BUS_RD) begin
			case (BUS_ADDR)
				mxr_pkg::REG_ACC: st_d.rdata = st_q.acc;
				mxr_pkg::REG_STATUS: st_d.rdata = {3'h0, st_q.flags};
				mxr_pkg::REG_IRQ_CTRL: st_d.rdata = {st_q.global_irq_enable, 7'h00};
				default: begin
					for (int i = 0; i < mxr_pkg::DIR_COUNT; i++) begin
						if (BUS_ADDR == mxr_pkg::REG_DIR_BASE + 3'(i)) begin
							st_d.rdata = st_q.dir[i];
						end
					end
				end
			endcase
		end
		// register writes
		if (BUS_WR) begin
			case (BUS_ADDR)
				mxr_pkg::REG_ACC: st_d.acc = BUS_WDATA;
				mxr_pkg::REG_STATUS: st_d.flags = BUS_WDATA[4:0];
				mxr_pkg::REG_IRQ_CTRL: st_d.global_irq_enable = BUS_WDATA[mxr_pkg::IRQ_ENABLE_BIT];
				default: begin
					for (int i = 0; i < mxr_pkg::DIR_COUNT; i++) begin
						if (BUS_ADDR == mxr_pkg::REG_DIR_BASE + 3'(i)) begin
							st_d.dir[i] = BUS_WDATA;
						end
					end
				end
			endcase
		end
		// wake request releases the halted core
		if (st_q.sleep && WAKE) begin
			st_d.sleep = 1'b0;
		end
		// instruction execution
		if (take) begin
			case (INSTR.op)
				mxr_pkg::OP_RETURN: begin
					st_d.pc_load = 1'b1;
					st_d.pc = STACK_TOP;
					st_d.busy = 1'b1;
				end
				mxr_pkg::OP_RET_IRQ: begin
					st_d.pc_load = 1'b1;
					st_d.pc = STACK_TOP;
					st_d.busy = 1'b1;
					st_d.global_irq_enable = 1'b1;
				end
				mxr_pkg::OP_RET_LIT: begin
					st_d.pc_load = 1'b1;
					st_d.pc = STACK_TOP;
					st_d.busy = 1'b1;
					st_d.acc = INSTR.lit;
				end
				mxr_pkg::OP_ROT_L: begin
					res = {FILE_RDATA[6:0], st_q.flags.carry};
					st_d.flags.carry = FILE_RDATA[7];
					wr_res = 1'b1;
				end
				mxr_pkg::OP_ROT_R: begin
					res = {st_q.flags.carry, FILE_RDATA[7:1]};
					st_d.flags.carry = FILE_RDATA[0];
					wr_res = 1'b1;
				end
				mxr_pkg::OP_SUB: begin
					res = sub_full[7:0];
					st_d.flags.carry = sub_full[8];
					st_d.flags.digit_carry_flag = sub_low[4];
					st_d.flags.zero = is_zero(sub_full[7:0]);
					wr_res = 1'b1;
				end
				mxr_pkg::OP_SWAP: begin
					res = {FILE_RDATA[3:0], FILE_RDATA[7:4]};
					wr_res = 1'b1;
				end
				mxr_pkg::OP_XOR_F: begin
					res = FILE_RDATA ^ st_q.acc;
					st_d.flags.zero = is_zero(res);
					wr_res = 1'b1;
				end
				mxr_pkg::OP_DIR_LOAD: begin
					// selectors other than 6..8 do nothing
					for (int i = 0; i < mxr_pkg::DIR_COUNT; i++) begin
						if (dir_hit(INSTR.lit, 8'(i))) begin
							st_d.dir[i] = st_q.acc;
						end
					end
				end
				mxr_pkg::OP_XOR_LIT: begin
					st_d.acc = st_q.acc ^ INSTR.lit;
					st_d.flags.zero = is_zero(st_q.acc ^ INSTR.lit);
				end
				mxr_pkg::OP_SLEEP: begin
					st_d.watchdog_clr = 1'b1;
					st_d.sleep = 1'b1;
					st_d.flags.timeout_flag = 1'b1;
					st_d.flags.powerdown_flag = 1'b0;
				end
				default: begin
				end
			endcase
			// destination select for file operand results
			if (wr_res) begin
				if (INSTR.dest == mxr_pkg::DEST_ACC) begin
					st_d.acc = res;
				end else begin
					st_d.fwe = 1'b1;
					st_d.faddr = INSTR.faddr;
					st_d.fdata = res;
				end
			end
		end
	end

	// state register
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			st_q <= '0;
			st_q.acc <= mxr_pkg::ACC_RST;
			st_q.flags <= mxr_pkg::FLAGS_RST;
			st_q.dir <= {mxr_pkg::DIR_COUNT{mxr_pkg::DIR_RST}};
		end else begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, all from the state register

	assign BUS_RDATA = st_q.rdata;
	assign BUSY = st_q.busy;
	assign SLEEPING = st_q.sleep;
	assign PC_LOAD = st_q.pc_load;
	assign PC_VALUE = st_q.pc;
	assign FILE_WE = st_q.fwe;
	assign FILE_WADDR = st_q.faddr;
	assign FILE_WDATA = st_q.fdata;
	assign WATCHDOG_CLEAR = st_q.watchdog_clr;
	assign ACC = st_q.acc;
	assign FLAGS = st_q.flags;
	assign GLOBAL_IRQ_ENABLE = st_q.global_irq_enable;
	assign PIN_DIR = st_q.dir;

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_ret_irq_enable: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_RET_IRQ |=> GLOBAL_IRQ_ENABLE && PC_LOAD
		&& PC_VALUE == $past(STACK_TOP) && FLAGS == $past(FLAGS) ##1 !BUSY)
		else $error("irq return did not reload pc and enable irqs");

	a_ret_lit_acc: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_RET_LIT |=> ACC == $past(INSTR.lit)
		&& PC_LOAD && FLAGS == $past(FLAGS))
		else $error("literal return did not load acc");

	a_ret_two_cycles: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_RETURN |=> BUSY && PC_LOAD ##1 !BUSY && !PC_LOAD)
		else $error("return did not take two cycles");

	a_dest_file: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_SWAP |=> FILE_WE == $past(INSTR.dest)
		&& (FILE_WE || ACC == {$past(FILE_RDATA[3:0]), $past(FILE_RDATA[7:4])}))
		else $error("destination select wrong");

	a_rot_left: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_ROT_L && INSTR.dest |=>
		FILE_WDATA == {$past(FILE_RDATA[6:0]), $past(FLAGS.carry)}
		&& FLAGS.carry == $past(FILE_RDATA[7]) && FLAGS.zero == $past(FLAGS.zero))
		else $error("rotate left wrong");

	a_rot_right: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_ROT_R && INSTR.dest |=>
		FILE_WDATA == {$past(FLAGS.carry), $past(FILE_RDATA[7:1])}
		&& FLAGS.carry == $past(FILE_RDATA[0]))
		else $error("rotate right wrong");

	a_sleep_halt: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_SLEEP ##1 !WAKE |=> WATCHDOG_CLEAR == 1'b0 && SLEEPING)
		else $error("sleep did not halt");

	a_sleep_flags: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_SLEEP |=> WATCHDOG_CLEAR && FLAGS.timeout_flag
		&& !FLAGS.powerdown_flag && FLAGS.carry == $past(FLAGS.carry))
		else $error("sleep status flags wrong");

	a_sub_carry: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_SUB |=>
		FLAGS.carry == ($past(FILE_RDATA) >= $past(ACC))
		&& FLAGS.zero == ($past(FILE_RDATA) == $past(ACC)))
		else $error("subtract flags wrong");

	a_swap_flags: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_SWAP |=> FLAGS == $past(FLAGS))
		else $error("swap changed flags");

	a_xor_file: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_XOR_F && !INSTR.dest |=>
		ACC == ($past(ACC) ^ $past(FILE_RDATA)) && FLAGS.zero == (ACC == 8'h00)
		&& FLAGS.carry == $past(FLAGS.carry))
		else $error("file xor wrong");

	a_dir_load: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_DIR_LOAD && INSTR.lit == 8'h07 |=>
		PIN_DIR[1] == $past(ACC) && PIN_DIR[0] == $past(PIN_DIR[0]))
		else $error("direction load wrong");

	a_xor_lit: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		take && INSTR.op == mxr_pkg::OP_XOR_LIT |=>
		ACC == ($past(ACC) ^ $past(INSTR.lit)) && FLAGS.zero == (ACC == 8'h00))
		else $error("literal xor wrong");

endmodule // mxr_exec

//--- mxr_exec_bench.sv
// self-checking bench for the return, logic and control executor
`timescale 1ns/1ps

module mxr_exec_bench;
	localparam int PC_W = 11;
	// one table row: op, literal, file data, acc before, result, dest, flags in, flags out
	typedef struct {
		logic [3:0] op;
		logic [7:0] lit, fd, acc, val;
		logic d;
		logic [2:0] fin, fout;
	} mxr_row_t;
	logic clk = 1'b0, rst = 1'b1, valid = 1'b0, wake = 1'b0, bwr = 1'b0, brd = 1'b0;
	mxr_pkg::mxr_instr_t instr = '0;
	logic [7:0] frd = 8'h00, bwd = 8'h00, rdata, acc, fwd, rv;
	logic [2:0] badr = 3'h0;
	logic [PC_W-1:0] stk = '0, pcv;
	logic busy, sleeping, pcl, fwe, wdc, irq_en;
	logic [4:0] fwa;
	mxr_pkg::mxr_flags_t flags;
	logic [mxr_pkg::DIR_COUNT-1:0][7:0] pdir, xdir;
	int err_count = 0, num_checks = 0;
	mxr_row_t rows[13];

`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_count++; \
	$display("mismatch %s exp %h got %h", nm, ex, gt); end end

	mxr_exec #(.PC_W(PC_W)) i_dut (.CLOCK(clk), .SYS_RST(rst), .INSTR_VALID(valid),
		.INSTR(instr), .FILE_RDATA(frd), .STACK_TOP(stk), .WAKE(wake), .BUS_ADDR(badr),
		.BUS_WDATA(bwd), .BUS_WR(bwr), .BUS_RD(brd), .BUS_RDATA(rdata), .BUSY(busy),
		.SLEEPING(sleeping), .PC_LOAD(pcl), .PC_VALUE(pcv), .FILE_WE(fwe), .FILE_WADDR(fwa),
		.FILE_WDATA(fwd), .WATCHDOG_CLEAR(wdc), .ACC(acc), .FLAGS(flags),
		.GLOBAL_IRQ_ENABLE(irq_en), .PIN_DIR(pdir));

	// free-running 100 MHz clock
	initial forever #5 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	// one-cycle register write, no wait states
	task automatic bw(input logic [2:0] a, input logic [7:0] dt);
		@(posedge clk);
		bwr <= 1'b1;
		badr <= a;
		bwd <= dt;
		@(posedge clk);
		bwr <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe
	task automatic br(input logic [2:0] a, output logic [7:0] dt);
		@(posedge clk);
		brd <= 1'b1;
		badr <= a;
		@(posedge clk);
		brd <= 1'b0;
		#1 dt = rdata;
	endtask

	// one instruction; returns just after the taking edge
	task automatic issue(input logic [3:0] op, input logic [7:0] lit, input logic [4:0] fa,
		input logic d, input logic [7:0] fd);
		@(posedge clk);
		instr <= '{mxr_pkg::mxr_op_t'(op), lit, fa, d};
		frd <= fd;
		valid <= 1'b1;
		@(posedge clk);
		valid <= 1'b0;
		#1;
	endtask

	// bounded wait for the core to accept again
	task automatic settle;
		int n;
		n = 0;
		while ((busy !== 1'b0 || sleeping !== 1'b0) && n < 8) begin
			@(posedge clk);
			#1 n++;
		end
		if (busy !== 1'b0 || sleeping !== 1'b0) begin
			`CHK("settle", 1'b0, busy | sleeping)
			summarize();
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		// zero results on rotate and swap must leave zero alone
		rows = '{'{4'h4, 8'h00, 8'h81, 8'h11, 8'h02, 1'b0, 3'h0, 3'h1},
			'{4'h4, 8'h00, 8'h40, 8'h11, 8'h81, 1'b1, 3'h7, 3'h6},
			'{4'h5, 8'h00, 8'h01, 8'h11, 8'h00, 1'b0, 3'h0, 3'h1},
			'{4'h5, 8'h00, 8'h02, 8'h11, 8'h81, 1'b1, 3'h1, 3'h0},
			'{4'h6, 8'h00, 8'h05, 8'h05, 8'h00, 1'b0, 3'h0, 3'h7},
			'{4'h6, 8'h00, 8'h10, 8'h01, 8'h0f, 1'b1, 3'h0, 3'h1},
			'{4'h6, 8'h00, 8'h00, 8'h01, 8'hff, 1'b0, 3'h5, 3'h0},
			'{4'h7, 8'h00, 8'ha5, 8'h11, 8'h5a, 1'b0, 3'h5, 3'h5},
			'{4'h7, 8'h00, 8'h00, 8'h11, 8'h00, 1'b1, 3'h2, 3'h2},
			'{4'h8, 8'h00, 8'h3c, 8'h3c, 8'h00, 1'b0, 3'h3, 3'h7},
			'{4'h8, 8'h00, 8'hf0, 8'h0f, 8'hff, 1'b1, 3'h7, 3'h3},
			'{4'ha, 8'hff, 8'h00, 8'hff, 8'h00, 1'b0, 3'h0, 3'h4},
			'{4'ha, 8'h80, 8'h00, 8'h00, 8'h80, 1'b0, 3'h7, 3'h3}};
		xdir = {3{8'hff}};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1 `CHK("flags", 5'h18, flags)
		`CHK("pin_dir", xdir, pdir)
		bw(3'h7, 8'h55);
		br(3'h7, rv);
		`CHK("unmapped", 8'h00, rv)
		$display("test power-up done");
		// table of register and literal operations
		foreach (rows[i]) begin
			bw(mxr_pkg::REG_ACC, rows[i].acc);
			bw(mxr_pkg::REG_STATUS, {5'h03, rows[i].fin});
			issue(rows[i].op, rows[i].lit, 5'(i), rows[i].d, rows[i].fd);
			`CHK("flags", {2'b11, rows[i].fout}, flags)
			`CHK("acc", rows[i].d ? rows[i].acc : rows[i].val, acc)
			`CHK("file_we", rows[i].d, fwe)
			if (rows[i].d) `CHK("file_wr", {5'(i), rows[i].val}, {fwa, fwd})
		end
		br(mxr_pkg::REG_STATUS, rv);
		`CHK("status", 8'h1b, rv)
		$display("test table done");
		// returns, each followed at once by an instruction that must be dropped
		bw(mxr_pkg::REG_STATUS, 8'h1d);
		for (int k = 0; k < 3; k++) begin
			bw(mxr_pkg::REG_ACC, 8'h3e);
			stk <= {3'(k + 1), 8'h5a};
			issue(4'h1 + 4'(k), 8'hc3, 5'h00, 1'b0, 8'h00);
			`CHK("pc_load", 1'b1, pcl)
			`CHK("pc_value", stk, pcv)
			`CHK("busy", 1'b1, busy)
			`CHK("irq_en", k > 0, irq_en)
			instr <= '{mxr_pkg::OP_XOR_LIT, 8'hff, 5'h00, 1'b0};
			valid <= 1'b1;
			@(posedge clk);
			valid <= 1'b0;
			#1 `CHK("pc_load", 1'b0, pcl)
			`CHK("busy", 1'b0, busy)
			`CHK("acc", k == 2 ? 8'hc3 : 8'h3e, acc)
			`CHK("flags", 5'h1d, flags)
		end
		br(mxr_pkg::REG_IRQ_CTRL, rv);
		`CHK("irq_ctrl", 1'b1, rv[mxr_pkg::IRQ_ENABLE_BIT])
		$display("test returns done");
		// direction loads, selectors just outside the range do nothing
		for (int s = 5; s < 10; s++) begin
			bw(mxr_pkg::REG_ACC, 8'h40 + 8'(s));
			issue(4'h9, 8'(s), 5'h00, 1'b0, 8'h00);
			if (s >= 6 && s <= 8) xdir[s - 6] = 8'h40 + 8'(s);
			`CHK("pin_dir", xdir, pdir)
			`CHK("flags", 5'h1d, flags)
		end
		br(mxr_pkg::REG_DIR_BASE + 3'h1, rv);
		`CHK("dir_reg", 8'h47, rv)
		$display("test direction done");
		// sleep: pulse, status bits, halted core, wake
		issue(4'hb, 8'h00, 5'h00, 1'b0, 8'h00);
		`CHK("watchdog_clear", 1'b1, wdc)
		`CHK("sleeping", 1'b1, sleeping)
		`CHK("flags", 5'h15, flags)
		issue(4'ha, 8'hff, 5'h00, 1'b0, 8'h00);
		`CHK("watchdog_clear", 1'b0, wdc)
		`CHK("acc", 8'h49, acc)
		wake = 1'b1;
		@(posedge clk);
		#1 `CHK("sleeping", 1'b0, sleeping)
		wake = 1'b0;
		settle();
		$display("test sleep done");
		// second reset in mid-run
		rst = 1'b1;
		#1 `CHK("acc", 8'h00, acc)
		`CHK("flags", 5'h18, flags)
		`CHK("pin_dir", {3{8'hff}}, pdir)
		`CHK("irq_en", 1'b0, irq_en)
		// release again, present an instruction at the first edge after release and take it at the next
		@(posedge clk);
		rst <= 1'b0;
		issue(4'ha, 8'h00, 5'h00, 1'b0, 8'h00);
		`CHK("flags", 5'h1c, flags)
		`CHK("acc", 8'h00, acc)
		`CHK("sleeping", 1'b0, sleeping)
		$display("test reset done");
		summarize();
	end
endmodule // mxr_exec_bench
